// *** hw/ssx_alu.sv ***
// Combinational result and flag computation for one operation.
// Assumes the caller commits the outputs at a single clock edge.
`timescale 1ns/10ps
module ssx_alu (
    // Operation
    input  ssx_pkg::ssx_cmd_t         cmd,
    // Operands
    input  wire logic [7:0]           acc,
    input  wire logic [7:0]           file_val,
    input  ssx_pkg::ssx_flags_t       flags_in,
    // Result
    output ssx_pkg::ssx_alu_t         alu_out
);
    import ssx_pkg::*;

    logic [8:0] sum;
    logic [4:0] low_sum;
    logic [7:0] sub_a;
    logic [7:0] sub_b;
    logic       cin;
    logic       to_dest;

    // ----------------------------------------------------------------
    // Subtractor shared by both subtract operations
    // ----------------------------------------------------------------
    always_comb begin
        if (cmd.op == OP_SUB_WITH_BORROW) begin
            sub_a = acc;                                          // RL4
            sub_b = file_val;
            cin   = flags_in.carry;
        end else begin
            sub_a = file_val;                                     // RL1
            sub_b = acc;
            cin   = 1'b1;
        end
        sum     = {1'b0, sub_a} + {1'b0, ~sub_b} + {8'h00, cin};
        low_sum = {1'b0, sub_a[3:0]} + {1'b0, ~sub_b[3:0]} + {4'h0, cin};
    end

    // ----------------------------------------------------------------
    // Operation select
    // ----------------------------------------------------------------
    always_comb begin
        to_dest                        = (cmd.dest == DEST_ACC);
        alu_out                        = '0;
        alu_out.flags                  = flags_in;
        alu_out.flags.carry            = sum[8];                  // RL2
        alu_out.flags.digit_carry_flag = low_sum[4];              // RL2
        case (cmd.op)
            OP_SUB_ACC_FROM_FILE, OP_SUB_WITH_BORROW: begin
                alu_out.result    = sum[7:0];
                alu_out.upd_carry = 1'b1;
                alu_out.upd_zero  = 1'b1;
                alu_out.to_acc    = to_dest;                      // RL3
                alu_out.to_file   = !to_dest;                     // RL3
            end
            OP_NIBBLE_SWAP_FILE: begin
                alu_out.result  = {file_val[3:0], file_val[7:4]}; // RL5
                alu_out.to_acc  = to_dest;                        // RL3
                alu_out.to_file = !to_dest;
            end
            OP_LOAD_DIRECTION_REG: begin
                alu_out.result = acc;                             // RL6
                alu_out.to_dir = (cmd.f >= SEL_DIR_A) && (cmd.f <= SEL_DIR_C);
                alu_out.bad    = !alu_out.to_dir;
            end
            OP_XOR_LITERAL_ACC: begin
                alu_out.result   = acc ^ cmd.k;                   // RL7
                alu_out.upd_zero = 1'b1;
                alu_out.to_acc   = 1'b1;
            end
            OP_XOR_ACC_FILE: begin
                alu_out.result   = acc ^ file_val;                // RL8
                alu_out.upd_zero = 1'b1;
                alu_out.to_acc   = to_dest;                       // RL3
                alu_out.to_file  = !to_dest;
            end
            OP_NONE: begin
                alu_out.result = acc;
            end
            default: begin
                alu_out.result = acc;
                alu_out.bad    = 1'b1;
            end
        endcase
        alu_out.flags.zero = (alu_out.result == 8'h00);           // RL9
        if (!alu_out.upd_carry) begin
            alu_out.flags.carry            = flags_in.carry;
            alu_out.flags.digit_carry_flag = flags_in.digit_carry_flag;
        end
        if (!alu_out.upd_zero) begin
            alu_out.flags.zero = flags_in.zero;
        end
    end

endmodule // ssx_alu

// *** hw/ssx_datapath.sv ***
// Subtract, swap, xor and direction-load datapath with its register file.
// Assumes an Avalon-MM master with waitrequest; one clock, async reset.
//
// What this block does
// RL1: File minus accumulator, operand 0 to 127
// RL2: Carry and digit carry mean no borrow
// RL3: Destination bit 0 accumulator, 1 file register
// RL4: Borrow subtract: accumulator minus file minus borrow
// RL5: Swap file nibbles, flags unchanged
// RL6: Operand 5,6,7 loads port A,B,C direction
// RL7: Literal xor into accumulator, zero flag only
// RL8: File xor to destination, zero flag only
// RL9: Zero flag set when result is zero
// RL10: Result and flags commit in one cycle
`timescale 1ns/10ps
module ssx_datapath (
    // Clock and reset
    input  wire logic                          ref_clk,
    input  wire logic                          reset,
    // Avalon-MM slave
    input  wire logic [ssx_pkg::ADDR_W-1:0]    avs_address,
    input  wire logic                          avs_read,
    input  wire logic                          avs_write,
    input  wire logic [ssx_pkg::BUS_W-1:0]     avs_writedata,
    input  wire logic [3:0]                    avs_byteenable,
    output logic      [ssx_pkg::BUS_W-1:0]     avs_readdata,
    output logic                               avs_waitrequest,
    // Port direction registers
    output logic      [ssx_pkg::DATA_W-1:0]    port_a_direction,
    output logic      [ssx_pkg::DATA_W-1:0]    port_b_direction,
    output logic      [ssx_pkg::DATA_W-1:0]    port_c_direction,
    // Datapath state
    output logic      [ssx_pkg::DATA_W-1:0]    acc_out,
    output ssx_pkg::ssx_flags_t                flags_out
);
    import ssx_pkg::*;

    // ----------------------------------------------------------------
    // Byte lane merge
    // ----------------------------------------------------------------
    function automatic logic [BUS_W-1:0] merge_be(
        input logic [BUS_W-1:0] old_val,
        input logic [BUS_W-1:0] new_val,
        input logic [3:0]       be
    );
        logic [BUS_W-1:0] res;
        res = old_val;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                res[i*8 +: 8] = new_val[i*8 +: 8];
            end
        end
        return res;
    endfunction

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    logic [DATA_W-1:0]  acc;
    logic [DATA_W-1:0]  next_acc;
    ssx_flags_t         flags;
    ssx_flags_t         next_flags;
    logic               bad;
    logic               next_bad;
    logic [DATA_W-1:0]  dir_reg [DIR_N];
    logic [DATA_W-1:0]  next_dir_reg [DIR_N];
    logic [DATA_W-1:0]  file_mem [FILE_N];
    logic [DATA_W-1:0]  next_file_mem [FILE_N];
    logic [FADDR_W-1:0] ptr;
    logic [FADDR_W-1:0] next_ptr;
    ssx_cmd_t           cmd_last;
    ssx_cmd_t           next_cmd_last;
    logic               wait_q;
    logic               next_wait_q;
    logic [BUS_W-1:0]   rdata;
    logic [BUS_W-1:0]   next_rdata;

    // ----------------------------------------------------------------
    // Bus decode and execution
    // ----------------------------------------------------------------
    logic               req;
    logic               commit;
    logic               wr_commit;
    ssx_cmd_t           cmd_in;
    logic [DATA_W-1:0]  file_val;
    ssx_alu_t           alu_res;
    logic [BUS_W-1:0]   cmd_merged;

    assign req        = avs_read || avs_write;
    assign commit     = req && !wait_q;
    assign wr_commit  = commit && avs_write;
    assign cmd_merged = merge_be({8'h00, cmd_last}, avs_writedata, avs_byteenable);
    assign cmd_in     = ssx_cmd_t'(cmd_merged[23:0]);
    assign file_val   = file_mem[cmd_in.f];

    ssx_alu u_alu (
        .cmd      (cmd_in),
        .acc      (acc),
        .file_val (file_val),
        .flags_in (flags),
        .alu_out  (alu_res)
    );

    // ----------------------------------------------------------------
    // Handshake and read data
    // ----------------------------------------------------------------
    always_comb begin
        next_wait_q = !(req && wait_q);
        next_rdata  = rdata;
        if (req && wait_q) begin
            case (avs_address)
                OFF_CMD:       next_rdata = {8'h00, cmd_last};
                OFF_ACC:       next_rdata = {24'h00_0000, acc};
                OFF_STATUS:    next_rdata = {28'h000_0000, bad, flags};
                OFF_DIR_A:     next_rdata = {24'h00_0000, dir_reg[0]};
                OFF_DIR_B:     next_rdata = {24'h00_0000, dir_reg[1]};
                OFF_DIR_C:     next_rdata = {24'h00_0000, dir_reg[2]};
                OFF_FILE_PTR:  next_rdata = {25'h000_0000, ptr};
                OFF_FILE_DATA: next_rdata = {24'h00_0000, file_mem[ptr]};
                default:       next_rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            wait_q <= 1'b1;
            rdata  <= 32'h0000_0000;
        end else begin
            wait_q <= next_wait_q;
            rdata  <= next_rdata;
        end
    end

    // ----------------------------------------------------------------
    // Accumulator, flags, pointer and command
    // ----------------------------------------------------------------
    always_comb begin
        next_acc      = acc;
        next_flags    = flags;
        next_bad      = bad;
        next_ptr      = ptr;
        next_cmd_last = cmd_last;
        if (wr_commit && avs_byteenable[0]) begin
            case (avs_address)
                OFF_ACC:      next_acc = avs_writedata[7:0];
                OFF_STATUS: begin
                    next_flags.carry            = avs_writedata[ST_CARRY];
                    next_flags.digit_carry_flag = avs_writedata[ST_DIGIT];
                    next_flags.zero             = avs_writedata[ST_ZERO];
                    next_bad                    = avs_writedata[ST_BAD];
                end
                OFF_FILE_PTR: next_ptr = avs_writedata[FADDR_W-1:0];
                default:      next_ptr = ptr;
            endcase
        end
        if (wr_commit && avs_address == OFF_CMD) begin
            next_cmd_last = cmd_in;
            if (alu_res.to_acc) begin
                next_acc = alu_res.result;                        // RL10
            end
            next_flags = alu_res.flags;                           // RL10
            if (alu_res.bad) begin
                next_bad = 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            acc      <= ACC_RST;
            flags    <= '0;
            bad      <= 1'b0;
            ptr      <= PTR_RST;
            cmd_last <= ssx_cmd_t'(CMD_RST);
        end else begin
            acc      <= next_acc;
            flags    <= next_flags;
            bad      <= next_bad;
            ptr      <= next_ptr;
            cmd_last <= next_cmd_last;
        end
    end

    // ----------------------------------------------------------------
    // Direction registers
    // ----------------------------------------------------------------
    for (genvar d = 0; d < DIR_N; d++) begin : g_dir
        localparam logic [FADDR_W-1:0] SEL = FADDR_W'(SEL_DIR_A + d);
        localparam logic [ADDR_W-1:0]  OFF = ADDR_W'(OFF_DIR_A + 4 * d);

        always_comb begin
            next_dir_reg[d] = dir_reg[d];
            if (wr_commit && avs_address == OFF && avs_byteenable[0]) begin
                next_dir_reg[d] = avs_writedata[7:0];
            end
            if (wr_commit && avs_address == OFF_CMD && alu_res.to_dir && cmd_in.f == SEL) begin
                next_dir_reg[d] = alu_res.result;                 // RL6
            end
        end

        always_ff @(posedge ref_clk or posedge reset) begin
            if (reset) begin
                dir_reg[d] <= DIR_RST;
            end else begin
                dir_reg[d] <= next_dir_reg[d];
            end
        end
    end

    // ----------------------------------------------------------------
    // File register array
    // ----------------------------------------------------------------
    always_comb begin
        for (int i = 0; i < FILE_N; i++) begin
            next_file_mem[i] = file_mem[i];
        end
        if (wr_commit && avs_address == OFF_FILE_DATA && avs_byteenable[0]) begin
            next_file_mem[ptr] = avs_writedata[7:0];
        end
        if (wr_commit && avs_address == OFF_CMD && alu_res.to_file) begin
            next_file_mem[cmd_in.f] = alu_res.result;             // RL3
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            for (int i = 0; i < FILE_N; i++) begin
                file_mem[i] <= FILE_RST;
            end
        end else begin
            for (int i = 0; i < FILE_N; i++) begin
                file_mem[i] <= next_file_mem[i];
            end
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign avs_readdata     = rdata;
    assign avs_waitrequest  = wait_q;
    assign port_a_direction = dir_reg[0];
    assign port_b_direction = dir_reg[1];
    assign port_c_direction = dir_reg[2];
    assign acc_out          = acc;
    assign flags_out        = flags;

endmodule // ssx_datapath

// *** hw/ssx_pkg.sv ***
// Constants, register map and carrier types of the subtract/swap/xor datapath.
// Assumes a single 100 MHz clock and an Avalon-MM slave port for software.
package ssx_pkg;

    // ----------------------------------------------------------------
    // Widths
    // ----------------------------------------------------------------
    localparam int DATA_W  = 8;
    localparam int FADDR_W = 7;
    localparam int FILE_N  = 128;
    localparam int BUS_W   = 32;
    localparam int ADDR_W  = 5;
    localparam int DIR_N   = 3;

    // ----------------------------------------------------------------
    // Register byte offsets
    // ----------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFF_CMD       = 5'h00;
    localparam logic [ADDR_W-1:0] OFF_ACC       = 5'h04;
    localparam logic [ADDR_W-1:0] OFF_STATUS    = 5'h08;
    localparam logic [ADDR_W-1:0] OFF_DIR_A     = 5'h0C;
    localparam logic [ADDR_W-1:0] OFF_DIR_B     = 5'h10;
    localparam logic [ADDR_W-1:0] OFF_DIR_C     = 5'h14;
    localparam logic [ADDR_W-1:0] OFF_FILE_PTR  = 5'h18;
    localparam logic [ADDR_W-1:0] OFF_FILE_DATA = 5'h1C;

    // ----------------------------------------------------------------
    // Status field positions
    // ----------------------------------------------------------------
    localparam int ST_CARRY = 0;
    localparam int ST_DIGIT = 1;
    localparam int ST_ZERO  = 2;
    localparam int ST_BAD   = 3;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [DATA_W-1:0]  ACC_RST  = 8'h00;
    localparam logic [DATA_W-1:0]  DIR_RST  = 8'hFF;
    localparam logic [DATA_W-1:0]  FILE_RST = 8'h00;
    localparam logic [FADDR_W-1:0] PTR_RST  = 7'h00;
    localparam logic [23:0]        CMD_RST  = 24'h00_0000;

    // ----------------------------------------------------------------
    // Operand values
    // ----------------------------------------------------------------
    localparam logic [FADDR_W-1:0] SEL_DIR_A = 7'h05;
    localparam logic [FADDR_W-1:0] SEL_DIR_C = 7'h07;
    localparam logic               DEST_ACC  = 1'b0;

    // ----------------------------------------------------------------
    // Operation codes
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        OP_NONE               = 3'h0,
        OP_SUB_ACC_FROM_FILE  = 3'h1,
        OP_SUB_WITH_BORROW    = 3'h2,
        OP_NIBBLE_SWAP_FILE   = 3'h3,
        OP_LOAD_DIRECTION_REG = 3'h4,
        OP_XOR_LITERAL_ACC    = 3'h5,
        OP_XOR_ACC_FILE       = 3'h6
    } ssx_op_t;

    // ----------------------------------------------------------------
    // Carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [7:0]         k;
        logic [4:0]         spare;
        logic [FADDR_W-1:0] f;
        logic               dest;
        ssx_op_t            op;
    } ssx_cmd_t;

    typedef struct packed {
        logic zero;
        logic digit_carry_flag;
        logic carry;
    } ssx_flags_t;

    typedef struct packed {
        logic [DATA_W-1:0] result;
        ssx_flags_t        flags;
        logic              upd_carry;
        logic              upd_zero;
        logic              to_acc;
        logic              to_file;
        logic              to_dir;
        logic              bad;
    } ssx_alu_t;

endpackage

// *** tb/ssx_datapath_asserts.sv ***
// Port-level checks of the subtract/swap/xor datapath.
// Assumes one clock, async reset and the Avalon-MM timing of the design.
`timescale 1ns/10ps
module ssx_datapath_asserts (
    // Clock and reset
    input wire logic                        ref_clk,
    input wire logic                        reset,
    // Avalon-MM slave
    input wire logic [ssx_pkg::ADDR_W-1:0]  avs_address,
    input wire logic                        avs_read,
    input wire logic                        avs_write,
    input wire logic [ssx_pkg::BUS_W-1:0]   avs_writedata,
    input wire logic [3:0]                  avs_byteenable,
    input wire logic                        avs_waitrequest,
    // Datapath state
    input wire logic [ssx_pkg::DATA_W-1:0]  port_a_direction,
    input wire logic [ssx_pkg::DATA_W-1:0]  port_b_direction,
    input wire logic [ssx_pkg::DATA_W-1:0]  port_c_direction,
    input wire logic [ssx_pkg::DATA_W-1:0]  acc_out,
    input ssx_pkg::ssx_flags_t              flags_out
);
    import ssx_pkg::*;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);
    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    ssx_cmd_t   cw;
    logic       go;
    logic [7:0] prev_acc;
    logic [8:0] sum9;
    logic [4:0] sum5;
    assign cw   = ssx_cmd_t'(avs_writedata[23:0]);
    assign go   = avs_write && !avs_waitrequest && avs_address == OFF_CMD
                  && avs_byteenable == 4'hF;
    assign sum9 = {1'b0, acc_out} + {1'b0, prev_acc};
    assign sum5 = {1'b0, acc_out[3:0]} + {1'b0, prev_acc[3:0]};
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            prev_acc <= 8'h00;
        end else begin
            prev_acc <= acc_out;
        end
    end
    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    a_wait_answer: assert property ((avs_read || avs_write) && avs_waitrequest
        |=> !avs_waitrequest) else $error("request not answered next cycle");
    a_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low too long");
    a_wait_idle: assert property (!avs_read && !avs_write && avs_waitrequest
        |=> avs_waitrequest) else $error("answer without request");
    a_state_hold: assert property (!(avs_write && !avs_waitrequest)
        |=> $stable(acc_out) && $stable(flags_out)) else $error("state moved unasked");
    a_dir_hold: assert property (!(avs_write && !avs_waitrequest)
        |=> $stable({port_a_direction, port_b_direction, port_c_direction}))
        else $error("direction moved unasked");
    a_xorl_acc: assert property (go && cw.op == OP_XOR_LITERAL_ACC
        |=> acc_out == ($past(acc_out) ^ $past(cw.k)) && flags_out.zero == (acc_out == 8'h00)
        && flags_out.carry == $past(flags_out.carry)) else $error("literal xor wrong");
    a_dir_load: assert property (go && cw.op == OP_LOAD_DIRECTION_REG && cw.f == SEL_DIR_A
        |=> port_a_direction == $past(acc_out) && flags_out == $past(flags_out))
        else $error("direction load wrong");
    a_swap_flags: assert property (go && cw.op == OP_NIBBLE_SWAP_FILE
        |=> flags_out == $past(flags_out)) else $error("swap touched flags");
    a_xorf_zero: assert property (go && cw.op == OP_XOR_ACC_FILE && cw.dest == DEST_ACC
        |=> flags_out.zero == (acc_out == 8'h00) && flags_out.carry == $past(flags_out.carry))
        else $error("file xor flags wrong");
    a_sub_flags: assert property (go && cw.op == OP_SUB_ACC_FROM_FILE && cw.dest == DEST_ACC
        |=> flags_out.carry == !sum9[8] && flags_out.digit_carry_flag == !sum5[4]
        && flags_out.zero == (acc_out == 8'h00)) else $error("subtract flags wrong");
    c_borrow: cover property (go && cw.op == OP_SUB_WITH_BORROW);
    c_dir_load: cover property (go && cw.op == OP_LOAD_DIRECTION_REG);
    c_read: cover property (avs_read && !avs_waitrequest);
endmodule // ssx_datapath_asserts
bind ssx_datapath ssx_datapath_asserts u_chk (.ref_clk(ref_clk), .reset(reset),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_waitrequest(avs_waitrequest), .port_a_direction(port_a_direction),
    .port_b_direction(port_b_direction), .port_c_direction(port_c_direction),
    .acc_out(acc_out), .flags_out(flags_out));

// *** tb/ssx_datapath_tb.sv ***
// Self-checking bench of the subtract/swap/xor datapath.
// Assumes the design's Avalon-MM slave answers through waitrequest.
`timescale 1ns/10ps
module ssx_datapath_tb;
    import ssx_pkg::*;
    // ----------------------------------------------------------------
    // Signals
    // ----------------------------------------------------------------
    logic              ref_clk;
    logic              reset;
    logic [ADDR_W-1:0] avs_address;
    logic              avs_read;
    logic              avs_write;
    logic [BUS_W-1:0]  avs_writedata;
    logic [3:0]        avs_byteenable;
    logic [BUS_W-1:0]  avs_readdata;
    logic              avs_waitrequest;
    logic [7:0]        dir_a;
    logic [7:0]        dir_b;
    logic [7:0]        dir_c;
    logic [7:0]        acc_out;
    ssx_flags_t        flags_out;
    int                num_errors;
    int                total_checks;
    int                cycles;
    logic [31:0]       q;
    logic [7:0]        av[4] = '{8'h10, 8'h06, 8'h01, 8'h02};
    logic [7:0]        fv[4] = '{8'h10, 8'h05, 8'h20, 8'h13};

    ssx_datapath u_dut (.ref_clk(ref_clk), .reset(reset), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .port_a_direction(dir_a),
        .port_b_direction(dir_b), .port_c_direction(dir_c), .acc_out(acc_out),
        .flags_out(flags_out));

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 5000) begin
            num_errors++;
            report_and_stop();
        end
    end
    // ----------------------------------------------------------------
    // Bus and compare tasks
    // ----------------------------------------------------------------
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= !w;
        @(posedge ref_clk);
        while (avs_waitrequest !== 1'b0) @(posedge ref_clk);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rd(input logic [4:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0000_0000);
        check(q, exp);
    endtask
    task automatic op(input logic [2:0] o, input logic d, input logic [6:0] f,
                      input logic [7:0] k);
        wr(OFF_CMD, {8'h00, k, 5'h00, f, d, o});
    endtask
    task automatic setup(input logic [7:0] a, input logic [6:0] f, input logic [7:0] v,
                         input logic [31:0] st);
        wr(OFF_ACC, 32'(a));
        wr(OFF_FILE_PTR, 32'(f));
        wr(OFF_FILE_DATA, 32'(v));
        wr(OFF_STATUS, st);
    endtask
    task automatic expect_res(input logic d, input logic [7:0] a, input logic [7:0] r,
                              input logic [2:0] fl);
        if (d) begin
            check(32'(acc_out), 32'(a));
            rd(OFF_FILE_DATA, 32'(r));
        end else begin
            check(32'(acc_out), 32'(r));
        end
        check(32'(flags_out), 32'(fl));
    endtask
    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_reset();
        check(32'({dir_a, dir_b, dir_c}), 32'h00FF_FFFF);
        check(32'(acc_out), 32'h0000_0000);
        rd(5'h02, 32'h0000_0000);
    endtask
    task automatic t_sub();
        logic [8:0] t9;
        logic [4:0] t5;
        logic       b;
        for (int j = 1; j <= 2; j++) begin
            for (int i = 0; i < 4; i++) begin
                b = (j == 2) && !i[1];
                setup(av[i], i[0] ? 7'h7F : 7'h00, fv[i], {31'h0, i[1]});
                op(j[2:0], i[0], i[0] ? 7'h7F : 7'h00, 8'h00);
                if (j == 1) begin
                    t9 = {1'b0, fv[i]} - {1'b0, av[i]};
                    t5 = {1'b0, fv[i][3:0]} - {1'b0, av[i][3:0]};
                end else begin
                    t9 = {1'b0, av[i]} - {1'b0, fv[i]} - {8'h00, b};
                    t5 = {1'b0, av[i][3:0]} - {1'b0, fv[i][3:0]} - {4'h0, b};
                end
                expect_res(i[0], av[i], t9[7:0], {t9[7:0] == 8'h00, !t5[4], !t9[8]});
            end
        end
    endtask
    task automatic t_swap_xor();
        for (int d = 0; d < 2; d++) begin
            setup(8'h33, 7'h40, 8'hA5, 32'h0000_0007);
            op(3'h3, d[0], 7'h40, 8'h00);
            expect_res(d[0], 8'h33, 8'h5A, 3'b111);
            setup(8'h5A, 7'h22, d[0] ? 8'h5A : 8'h0F, 32'h0000_0003);
            op(3'h6, d[0], 7'h22, 8'h00);
            expect_res(d[0], 8'h5A, d[0] ? 8'h00 : 8'h55, {d[0], 2'b11});
        end
        setup(8'h5A, 7'h22, 8'h0F, 32'h0000_0001);
        op(3'h5, 1'b1, 7'h22, 8'h5A);
        check(32'(acc_out), 32'h0000_0000);
        check(32'(flags_out), 32'h0000_0005);
        rd(OFF_FILE_DATA, 32'h0000_000F);
        op(3'h5, 1'b0, 7'h00, 8'hFF);
        check(32'(acc_out), 32'h0000_00FF);
        check(32'(flags_out), 32'h0000_0001);
    endtask
    task automatic t_dir();
        wr(OFF_STATUS, 32'h0000_0005);
        for (int f = 5; f < 8; f++) begin
            wr(OFF_ACC, 32'h30 + f);
            op(3'h4, 1'b0, f[6:0], 8'h00);
            check(32'(f == 5 ? dir_a : f == 6 ? dir_b : dir_c), 32'h30 + f);
            check(32'(flags_out), 32'h0000_0005);
        end
        rd(OFF_STATUS, 32'h0000_0005);
        op(3'h4, 1'b0, 7'h04, 8'h00);
        op(3'h7, 1'b0, 7'h05, 8'h00);
        op(3'h0, 1'b0, 7'h05, 8'h00);
        check(32'({dir_a, dir_b, dir_c}), 32'h0035_3637);
        rd(OFF_STATUS, 32'h0000_000D);
        avs_byteenable <= 4'hE;
        wr(OFF_ACC, 32'h0000_00FF);
        avs_byteenable <= 4'hF;
        check(32'(acc_out), 32'h0000_0037);
    endtask
    task automatic report_and_stop();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        reset = 1'b1;
        avs_address = 5'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0000_0000;
        avs_byteenable = 4'hF;
        num_errors = 0;
        total_checks = 0;
        cycles = 0;
        repeat (6) @(posedge ref_clk);
        reset <= 1'b0;
        @(posedge ref_clk);
        t_reset();
        t_sub();
        t_swap_xor();
        t_dir();
        report_and_stop();
    end
endmodule // ssx_datapath_tb
